// ===== hdl/pwo_pkg.sv
// Package for the 16-bit offset/reload PWM channel.
// Assumes a classic Wishbone slave with 32-bit data, word addressing by byte.
package pwo_pkg;
  // Register byte offsets
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_OFFSET_CTL = 5'h04;
  localparam logic [4:0] ADDR_RELOAD_CTL = 5'h08;
  localparam logic [4:0] ADDR_CLOCK_CTL = 5'h0c;
  localparam logic [4:0] ADDR_PHASE = 5'h10;
  localparam logic [4:0] ADDR_DUTY = 5'h14;
  localparam logic [4:0] ADDR_PERIOD = 5'h18;
  localparam logic [4:0] ADDR_OFFSET = 5'h1c;
  // Status: flags and counter, unmapped otherwise
  localparam logic [5:0] ADDR_FLAGS = 6'h20;
  localparam logic [5:0] ADDR_COUNTER = 6'h24;
  // Control register fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_ACTIVE_LOW_BIT = 4;
  localparam int CTL_MODE_LSB = 2;
  // Offset control fields
  localparam int OFC_MODE_LSB = 5;
  localparam int OFC_DIR_BIT = 4;
  localparam int OFC_MASTER_LSB = 0;
  // Reload control fields
  localparam int LDC_ARMED_BIT = 7;
  localparam int LDC_TRIGGER_BIT = 6;
  localparam int LDC_SEL_LSB = 0;
  // Clock control fields
  localparam int CKC_PRESCALE_LSB = 4;
  localparam int CKC_SOURCE_LSB = 0;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Output modes
  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_SET_MATCH = 2'h1;
  localparam logic [1:0] MODE_TOGGLE = 2'h2;
  localparam logic [1:0] MODE_CENTER = 2'h3;
  // Offset modes
  localparam logic [1:0] OFM_INDEPENDENT = 2'h0;
  localparam logic [1:0] OFM_SLAVE_START = 2'h1;
  localparam logic [1:0] OFM_ONE_SHOT = 2'h2;
  localparam logic [1:0] OFM_CONT_RESET = 2'h3;
  // Clock sources
  localparam logic [1:0] SRC_SYSTEM = 2'h0;
  localparam logic [1:0] SRC_FAST_OSC = 2'h1;
  localparam logic [1:0] SRC_SLOW_OSC = 2'h2;
  // Counter reload value after a repeat master match
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
endpackage

// ===== hdl/pwo_channel.sv
// One 16-bit PWM channel with offset modes and double-buffered reload.
// Assumes classic Wishbone on ref_clk_in; sibling triggers and oscillator
// ticks arrive from other clocks and are synchronised here.
`timescale 1ns/100ps
module pwo_channel #(
  parameter int CHANNEL = 0,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Oscillator ticks and sleep
  input wire logic fast_osc_tick_in,
  input wire logic slow_osc_tick_in,
  input wire logic sleep_in,
  // Sibling channels, one bit per channel
  input wire logic [3:0] sib_offset_match_in,
  input wire logic [3:0] sib_load_event_in,
  output logic offset_match_event_out,
  output logic load_event_out,
  // Pin and flags
  output logic pwm_out,
  output logic [3:0] match_flags_out
);
  logic [7:0] control_q;
  logic [7:0] ofs_ctl_q;
  logic [7:0] ld_ctl_q;
  logic [7:0] clk_ctl_q;
  logic [WIDTH-1:0] buf_q [4];
  logic [WIDTH-1:0] act_q [4];
  logic dir_buf_q;
  logic dir_act_q;
  logic [WIDTH-1:0] count_q;
  logic down_q;
  logic running_q;
  logic out_q;
  logic out_wr_q;
  logic out_wr_val_q;
  logic trig_seen_q;
  logic [3:0] match_q;
  logic [3:0] flags_q;
  logic [6:0] pre_cnt_q;
  logic [3:0] sib_om_s1_q, sib_om_s2_q, sib_om_s3_q;
  logic [3:0] sib_ld_s1_q, sib_ld_s2_q, sib_ld_s3_q;
  logic [1:0] osc_s1_q, osc_s2_q, osc_s3_q;
  logic sleep_s1_q, sleep_s2_q;
  logic ack_q;
  logic [31:0] rdat_q;

  wire logic enable = control_q[pwo_pkg::CTL_ENABLE_BIT];
  wire logic [1:0] mode = control_q[pwo_pkg::CTL_MODE_LSB +: 2];
  wire logic [1:0] offset_mode_sel = ofs_ctl_q[pwo_pkg::OFC_MODE_LSB +: 2];
  wire logic [1:0] master = ofs_ctl_q[pwo_pkg::OFC_MASTER_LSB +: 2];
  wire logic [1:0] ld_sel = ld_ctl_q[pwo_pkg::LDC_SEL_LSB +: 2];
  wire logic [1:0] src = clk_ctl_q[pwo_pkg::CKC_SOURCE_LSB +: 2];
  wire logic [2:0] pscale = clk_ctl_q[pwo_pkg::CKC_PRESCALE_LSB +: 3];
  wire logic center = (mode == pwo_pkg::MODE_CENTER);
  wire logic req = wb_cyc_in && wb_stb_in && !ack_q;
  wire logic wr = req && wb_we_in && wb_sel_in[0];

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge ref_clk_in)
  begin
    sib_om_s1_q <= sib_offset_match_in;
    sib_om_s2_q <= sib_om_s1_q;
    sib_om_s3_q <= sib_om_s2_q;
    sib_ld_s1_q <= sib_load_event_in;
    sib_ld_s2_q <= sib_ld_s1_q;
    sib_ld_s3_q <= sib_ld_s2_q;
    osc_s1_q <= {slow_osc_tick_in, fast_osc_tick_in};
    osc_s2_q <= osc_s1_q;
    osc_s3_q <= osc_s2_q;
    sleep_s1_q <= sleep_in;
    sleep_s2_q <= sleep_s1_q;
  end

  // Sibling pulses become single-cycle edges; own channel is reserved
  wire logic [3:0] om_rise = sib_om_s2_q & ~sib_om_s3_q;
  wire logic [3:0] ld_rise = sib_ld_s2_q & ~sib_ld_s3_q;
  wire logic master_hit = om_rise[master] && (int'(master) != CHANNEL);
  wire logic ld_trig = ld_rise[ld_sel] && (int'(ld_sel) != CHANNEL);

  // Source tick; system clock stops in sleep, oscillators keep going
  logic src_tick;
  always_comb
  begin
    case (src)
      pwo_pkg::SRC_SYSTEM: src_tick = !sleep_s2_q;
      pwo_pkg::SRC_FAST_OSC: src_tick = osc_s2_q[0] && !osc_s3_q[0];
      pwo_pkg::SRC_SLOW_OSC: src_tick = osc_s2_q[1] && !osc_s3_q[1];
      default: src_tick = 1'b0;
    endcase
  end

  // Prescaler: divide by 2^pscale, one-cycle enable out
  wire logic [6:0] pre_max = 7'((8'h01 << pscale) - 8'h01);
  wire logic tick = src_tick && (pre_cnt_q == pre_max);
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in || !enable)
      pre_cnt_q <= 7'h00;
    else if (src_tick)
      pre_cnt_q <= (pre_cnt_q == pre_max) ? 7'h00 : pre_cnt_q + 7'h01;
  end

  // Match terms against operating counts
  wire logic [WIDTH-1:0] ph = act_q[0];
  wire logic [WIDTH-1:0] dc = act_q[1];
  wire logic [WIDTH-1:0] pr = act_q[2];
  wire logic [WIDTH-1:0] of = act_q[3];
  wire logic [WIDTH-1:0] ca_up = pr - dc;
  wire logic [WIDTH-1:0] ca_dn = ca_up + 16'h0001;
  wire logic period_hit = center ? (down_q && count_q == 16'h0000) : (count_q == pr);
  wire logic phase_hit = !center && (count_q == ph);
  wire logic duty_hit = center ? (down_q && count_q == ca_dn) : (count_q == dc);
  wire logic ofs_hit = center ? ((count_q == of) && (down_q == dir_act_q))
                              : (count_q == of);
  wire logic run_tick = tick && running_q;
  wire logic period_ev = run_tick && period_hit;

  // Counter and run state per offset mode
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in || !enable)
    begin
      count_q <= pwo_pkg::COUNT_RESET;
      down_q <= 1'b0;
      running_q <= 1'b0;
    end
    else
    begin
      if (!running_q && (offset_mode_sel == pwo_pkg::OFM_INDEPENDENT))
        running_q <= 1'b1;
      else if (!running_q && master_hit)
        running_q <= 1'b1;
      if (running_q && master_hit && (offset_mode_sel == pwo_pkg::OFM_CONT_RESET))
      begin
        count_q <= pwo_pkg::COUNT_RESTART;
        down_q <= 1'b0;
      end
      else if (run_tick)
      begin
        if (period_ev)
        begin
          count_q <= pwo_pkg::COUNT_RESET;
          down_q <= 1'b0;
          if (offset_mode_sel == pwo_pkg::OFM_ONE_SHOT)
            running_q <= 1'b0;
        end
        else if (center && !down_q && count_q == pr)
          down_q <= 1'b1; // Top held a tick, both ends count twice
        else if (down_q)
          count_q <= count_q - 16'h0001;
        else
          count_q <= count_q + 16'h0001;
      end
    end
  end

  // Output state: in center mode active across 2*duty
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in || !enable)
      out_q <= 1'b0;
    else if (run_tick)
    begin
      case (mode)
        pwo_pkg::MODE_STANDARD:
          if (duty_hit)
            out_q <= 1'b0;
          else if (phase_hit)
            out_q <= 1'b1;
        pwo_pkg::MODE_SET_MATCH:
          if (out_wr_q)
            out_q <= out_wr_val_q;
          else if (phase_hit)
            out_q <= 1'b1;
        pwo_pkg::MODE_TOGGLE:
          if (phase_hit)
            out_q <= !out_q;
        pwo_pkg::MODE_CENTER:
          if (!down_q && count_q == ca_up)
            out_q <= 1'b1;
          else if (duty_hit)
            out_q <= 1'b0;
        default: out_q <= out_q;
      endcase
    end
  end

  // Software output write waits for the next PWM tick
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      out_wr_q <= 1'b0;
      out_wr_val_q <= 1'b0;
    end
    else if (wr && wb_adr_in == 6'(pwo_pkg::ADDR_CONTROL)
             && mode == pwo_pkg::MODE_SET_MATCH)
    begin
      out_wr_q <= 1'b1;
      out_wr_val_q <= wb_dat_in[pwo_pkg::CTL_OUT_BIT];
    end
    else if (run_tick)
      out_wr_q <= 1'b0;
  end

  // Control registers; output bit is hardware owned
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      control_q <= pwo_pkg::CONTROL_RESET;
      ofs_ctl_q <= 8'h00;
      clk_ctl_q <= 8'h00;
    end
    else if (wr)
    begin
      if (wb_adr_in == 6'(pwo_pkg::ADDR_CONTROL))
        control_q <= wb_dat_in[7:0] & 8'h9c;
      if (wb_adr_in == 6'(pwo_pkg::ADDR_OFFSET_CTL))
        ofs_ctl_q <= wb_dat_in[7:0] & 8'h63;
      if (wb_adr_in == 6'(pwo_pkg::ADDR_CLOCK_CTL))
        clk_ctl_q <= wb_dat_in[7:0] & 8'h73;
    end
  end

  // Reload arming; with the trigger bit set, a trigger must be seen before the period event
  wire logic armed = ld_ctl_q[pwo_pkg::LDC_ARMED_BIT];
  wire logic on_trig = ld_ctl_q[pwo_pkg::LDC_TRIGGER_BIT];
  wire logic do_load = period_ev && armed && (!on_trig || trig_seen_q);
  wire logic arm_wr = wr && wb_adr_in == 6'(pwo_pkg::ADDR_RELOAD_CTL);
  wire logic arm_now = arm_wr && wb_dat_in[pwo_pkg::LDC_ARMED_BIT] && !armed;
  logic arm_block_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      ld_ctl_q <= 8'h00;
      trig_seen_q <= 1'b0;
      arm_block_q <= 1'b0;
    end
    else
    begin
      if (arm_wr)
        ld_ctl_q <= wb_dat_in[7:0] & 8'hc3;
      else if (do_load && !arm_block_q)
        ld_ctl_q[pwo_pkg::LDC_ARMED_BIT] <= 1'b0;
      if (arm_now)
        arm_block_q <= running_q && count_q == pr;
      else if (period_ev)
        arm_block_q <= 1'b0;
      if (!armed || do_load)
        trig_seen_q <= 1'b0;
      else if (ld_trig)
        trig_seen_q <= 1'b1; // Registered, so it counts from the next period event
    end
  end

  // Shadow buffers and transfer, all four plus direction on load; direction alone also while stopped and disabled
  wire logic load_go = do_load && !arm_block_q;
  wire logic idle_load = !running_q && !enable;
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      dir_buf_q <= 1'b0;
      dir_act_q <= 1'b0;
    end
    else
    begin
      if (wr && wb_adr_in == 6'(pwo_pkg::ADDR_OFFSET_CTL))
        dir_buf_q <= wb_dat_in[pwo_pkg::OFC_DIR_BIT];
      if (load_go || idle_load)
        dir_act_q <= dir_buf_q;
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_counts
    always_ff @(posedge ref_clk_in)
    begin
      if (!reset_n_in)
      begin
        buf_q[i] <= pwo_pkg::COUNT_RESET;
        act_q[i] <= pwo_pkg::COUNT_RESET;
      end
      else
      begin
        if (wr && wb_adr_in == 6'(pwo_pkg::ADDR_PHASE + 5'(4 * i)))
          buf_q[i] <= wb_dat_in[WIDTH-1:0];
        if (load_go)
          act_q[i] <= buf_q[i];
      end
    end
  end

  // Match edges set flags; set wins over software clear
  wire logic [3:0] match_now = {ofs_hit, phase_hit, duty_hit, period_hit}
                               & {4{running_q && enable}};
  wire logic [3:0] flag_set = match_now & ~match_q;
  wire logic flag_wr = wr && wb_adr_in == pwo_pkg::ADDR_FLAGS;
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in || !enable)
    begin
      match_q <= 4'h0;
      flags_q <= 4'h0;
    end
    else
    begin
      match_q <= match_now;
      flags_q <= (flags_q & ~(flag_wr ? wb_dat_in[3:0] : 4'h0)) | flag_set;
    end
  end

  // Events to siblings, pin with polarity applied even when disabled
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      offset_match_event_out <= 1'b0;
      load_event_out <= 1'b0;
      pwm_out <= 1'b0;
      match_flags_out <= 4'h0;
    end
    else
    begin
      offset_match_event_out <= flag_set[3];
      load_event_out <= load_go;
      pwm_out <= out_q ^ control_q[pwo_pkg::CTL_ACTIVE_LOW_BIT];
      match_flags_out <= flags_q;
    end
  end

  // Wishbone read mux and one-cycle ack
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_in)
      6'(pwo_pkg::ADDR_CONTROL): rd_mux = {24'h0, control_q | {2'h0, out_q, 5'h00}};
      6'(pwo_pkg::ADDR_OFFSET_CTL): rd_mux = {24'h0, ofs_ctl_q | {3'h0, dir_buf_q, 4'h0}};
      6'(pwo_pkg::ADDR_RELOAD_CTL): rd_mux = {24'h0, ld_ctl_q};
      6'(pwo_pkg::ADDR_CLOCK_CTL): rd_mux = {24'h0, clk_ctl_q};
      6'(pwo_pkg::ADDR_PHASE): rd_mux = {16'h0, buf_q[0]};
      6'(pwo_pkg::ADDR_DUTY): rd_mux = {16'h0, buf_q[1]};
      6'(pwo_pkg::ADDR_PERIOD): rd_mux = {16'h0, buf_q[2]};
      6'(pwo_pkg::ADDR_OFFSET): rd_mux = {16'h0, buf_q[3]};
      pwo_pkg::ADDR_FLAGS: rd_mux = {28'h0, flags_q};
      pwo_pkg::ADDR_COUNTER: rd_mux = {16'h0, count_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      rdat_q <= req ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
endmodule

// ===== verif/pwo_channel_assertions.sv
// Port checks for the PWM channel.
// Assumes one clock and a master that holds each request until ack.
`timescale 1ns/100ps
module pwo_channel_assertions (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Wishbone
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Events, pin and flags
  input wire logic offset_match_event_out,
  input wire logic load_event_out,
  input wire logic pwm_out,
  input wire logic [3:0] match_flags_out
);
  logic ctl_wr;
  logic en_q;
  logic pol_q;
  assign ctl_wr = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
    && wb_adr_in == {1'b0, pwo_pkg::ADDR_CONTROL};
  // Mirrored at the take edge, so no lag against the design
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      en_q <= 1'b0;
      pol_q <= 1'b0;
    end
    else if (ctl_wr)
    begin
      en_q <= wb_dat_in[pwo_pkg::CTL_ENABLE_BIT];
      pol_q <= wb_dat_in[pwo_pkg::CTL_ACTIVE_LOW_BIT];
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd(logic [5:0] a);
    wb_ack_out && !wb_we_in && wb_adr_in == a;
  endsequence
  sequence s_idle;
    !en_q && $stable(pol_q);
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_out)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_DATA_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  AST_CTL_READ: assert property (s_rd({1'b0, pwo_pkg::ADDR_CONTROL}) |->
    wb_dat_out[31:8] == 24'h0 && !wb_dat_out[6] && wb_dat_out[1:0] == 2'h0
    && wb_dat_out[4] == pol_q && wb_dat_out[7] == en_q)
    else $error("control read wrong");
  AST_FLAG_READ: assert property (s_rd(pwo_pkg::ADDR_FLAGS) |->
    wb_dat_out[31:4] == 28'h0 && wb_dat_out[3:0] == match_flags_out)
    else $error("flag read wrong");
  AST_LOAD_PULSE: assert property (load_event_out |=> !load_event_out)
    else $error("load event not a pulse");
  AST_OFS_PULSE: assert property (offset_match_event_out |=> !offset_match_event_out)
    else $error("offset event not a pulse");
  AST_OFS_FLAG: assert property ($rose(offset_match_event_out) |->
    ##[0:3] match_flags_out[3])
    else $error("offset flag not set");
  AST_FLAGS_OFF: assert property (!en_q [*3] |-> match_flags_out == 4'h0)
    else $error("flags set while disabled");
  AST_IDLE_LEVEL: assert property (s_idle [*3] |-> pwm_out == pol_q)
    else $error("idle pin level wrong");
endmodule
bind pwo_channel pwo_channel_assertions pwo_channel_assertions_i (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .offset_match_event_out(offset_match_event_out), .load_event_out(load_event_out),
  .pwm_out(pwm_out), .match_flags_out(match_flags_out));

// ===== verif/pwo_sibling_model.sv
// Sibling channels as seen by one PWM channel.
// Assumes the bench fires each event with a one-cycle strobe.
`timescale 1ns/100ps
module pwo_sibling_model (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Bench commands, one bit per sibling
  input wire logic [3:0] fire_ofs_in,
  input wire logic [3:0] fire_ld_in,
  // Events toward the channel
  output logic [3:0] ofs_match_out,
  output logic [3:0] load_event_out
);
  logic [15:0] ofs_hist_q;
  logic [15:0] ld_hist_q;
  // Four-cycle levels, as from a master clocked no faster than us
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      ofs_hist_q <= 16'h0000;
      ld_hist_q <= 16'h0000;
    end
    else
    begin
      ofs_hist_q <= {ofs_hist_q[11:0], fire_ofs_in};
      ld_hist_q <= {ld_hist_q[11:0], fire_ld_in};
    end
  end
  assign ofs_match_out = ofs_hist_q[3:0] | ofs_hist_q[7:4] | ofs_hist_q[11:8] | ofs_hist_q[15:12];
  assign load_event_out = ld_hist_q[3:0] | ld_hist_q[7:4] | ld_hist_q[11:8] | ld_hist_q[15:12];
endmodule

// ===== verif/pwo_channel_tb.sv
// Self-checking bench for one PWM channel as channel 0.
// Assumes the system clock source gives one tick per clock, no prescale.
`timescale 1ns/100ps
module pwo_channel_tb;
  localparam logic [5:0] CTL = {1'b0, pwo_pkg::ADDR_CONTROL};
  localparam logic [5:0] OFC = {1'b0, pwo_pkg::ADDR_OFFSET_CTL};
  localparam logic [5:0] RLD = {1'b0, pwo_pkg::ADDR_RELOAD_CTL};
  localparam logic [5:0] PH = {1'b0, pwo_pkg::ADDR_PHASE};
  localparam logic [5:0] DC = {1'b0, pwo_pkg::ADDR_DUTY};
  localparam logic [5:0] PR = {1'b0, pwo_pkg::ADDR_PERIOD};
  localparam logic [5:0] CNT = pwo_pkg::ADDR_COUNTER;
  logic ref_clk, reset_n, cyc, stb, we, ack, ofs_ev, ld_ev, pwm, seen;
  logic [5:0] adr;
  logic [3:0] sel, fire_ofs, fire_ld, sib_ofs, sib_ld, flags;
  logic [31:0] wdat, rdat, rv, c1;
  int error_cnt, checked, hi, lo, ofs_cnt;
  pwo_channel pwo_channel_i (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .fast_osc_tick_in(1'b0), .slow_osc_tick_in(1'b0),
    .sleep_in(1'b0), .sib_offset_match_in(sib_ofs), .sib_load_event_in(sib_ld),
    .offset_match_event_out(ofs_ev), .load_event_out(ld_ev), .pwm_out(pwm),
    .match_flags_out(flags));
  pwo_sibling_model pwo_sibling_model_i (.ref_clk_in(ref_clk), .reset_n_in(reset_n),
    .fire_ofs_in(fire_ofs), .fire_ld_in(fire_ld), .ofs_match_out(sib_ofs),
    .load_event_out(sib_ld));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Counts offset events sent to siblings
  always @(posedge ref_clk)
  begin
    if (ofs_ev === 1'b1)
      ofs_cnt++;
  end
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input string n, input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, rv);
  endtask
  task automatic wait_load(input int n);
    seen = 1'b0;
    while (seen !== 1'b1 && n > 0)
    begin
      @(posedge ref_clk);
      seen = (ld_ev === 1'b1);
      n--;
    end
  endtask
  task automatic measure();
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (pwm !== 1'b0 && n < 100) begin @(posedge ref_clk); n++; end
    while (pwm !== 1'b1 && n < 200) begin @(posedge ref_clk); n++; end
    while (pwm === 1'b1 && n < 300) begin @(posedge ref_clk); n++; hi++; end
    while (pwm === 1'b0 && n < 400) begin @(posedge ref_clk); n++; lo++; end
  endtask
  task automatic fire(input logic [3:0] o, input logic [3:0] l);
    @(posedge ref_clk);
    fire_ofs <= o;
    fire_ld <= l;
    @(posedge ref_clk);
    fire_ofs <= 4'h0;
    fire_ld <= 4'h0;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
  initial
  begin
    {cyc, stb, we, adr, wdat, sel, fire_ofs, fire_ld, reset_n} = '0;
    error_cnt = 0;
    checked = 0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk("control", CTL, {24'h0, pwo_pkg::CONTROL_RESET});
    wb(1'b1, 6'h28, 32'hff);
    rd_chk("unmapped", 6'h28, 32'h0);
    wb(1'b1, CTL, 32'h7f);
    rd_chk("control_bits", CTL, 32'h1c);
    chk("idle_level", 32'h1, {31'h0, pwm});
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, CTL, 32'(m << 2));
      rd_chk("mode_field", CTL, 32'(m << 2));
    end
    $display("test registers done");
    wb(1'b1, PH, 32'h2);
    wb(1'b1, DC, 32'h6);
    wb(1'b1, PR, 32'h9);
    rd_chk("period_shadow", PR, 32'h9);
    wb(1'b1, RLD, 32'h80);
    wb(1'b1, CTL, 32'h80);
    wait_load(200);
    chk("load_first", 32'h1, {31'h0, seen});
    rd_chk("armed_cleared", RLD, 32'h0);
    measure();
    chk("std_high", 32'd4, hi);
    chk("std_low", 32'd6, lo);
    wb(1'b0, pwo_pkg::ADDR_FLAGS, 32'h0);
    chk("flags_set", 32'h7, rv & 32'h7);
    chk("flags_pins", 32'h7, {28'h0, flags} & 32'h7);
    wb(1'b1, DC, 32'h8);
    measure();
    chk("no_early_load", 32'd4, hi);
    wb(1'b1, RLD, 32'h80);
    wait_load(200);
    measure();
    chk("std_high_new", 32'd6, hi);
    wb(1'b1, DC, 32'h3);
    wb(1'b1, RLD, 32'hc1);
    wait_load(60);
    chk("load_held", 32'h0, {31'h0, seen});
    rd_chk("armed_held", RLD, 32'hc1);
    fire(4'h0, 4'h2);
    wait_load(100);
    chk("load_trig", 32'h1, {31'h0, seen});
    rd_chk("armed_trig", RLD, 32'h41);
    measure();
    chk("trig_high", 32'd1, hi);
    wb(1'b1, CTL, 32'h0);
    rd_chk("flags_off", pwo_pkg::ADDR_FLAGS, 32'h0);
    $display("test reload done");
    wb(1'b1, PR, 32'h7);
    wb(1'b1, DC, 32'h3);
    wb(1'b1, RLD, 32'h80);
    wb(1'b1, CTL, 32'hac);
    wait_load(200);
    measure();
    chk("ctr_high", 32'd6, hi);
    chk("ctr_low", 32'd10, lo);
    $display("test center done");
    wb(1'b1, CTL, 32'h0);
    wb(1'b1, OFC, 32'h21);
    wb(1'b1, CTL, 32'h80);
    wb(1'b0, CNT, 32'h0);
    c1 = rv;
    repeat (20) @(posedge ref_clk);
    rd_chk("slave_wait", CNT, c1);
    fire(4'h2, 4'h0);
    repeat (10) @(posedge ref_clk);
    // Two reads three ticks apart differ while running
    wb(1'b0, CNT, 32'h0);
    c1 = rv;
    wb(1'b0, CNT, 32'h0);
    chk("slave_run", 32'h1, {31'h0, rv !== c1});
    wb(1'b1, CTL, 32'h0);
    wb(1'b1, OFC, 32'h41);
    wb(1'b1, CTL, 32'h80);
    c1 = 32'(ofs_cnt);
    fire(4'h2, 4'h0);
    repeat (60) @(posedge ref_clk);
    rd_chk("oneshot_halt", CNT, 32'h0);
    repeat (3) @(posedge ref_clk);
    rd_chk("oneshot_still", CNT, 32'h0);
    rd_chk("oneshot_ran", pwo_pkg::ADDR_FLAGS, 32'hf);
    chk("ofs_event", 32'h1, 32'(ofs_cnt) - c1);
    wb(1'b1, CTL, 32'h0);
    wb(1'b1, OFC, 32'h61);
    wb(1'b1, CTL, 32'h80);
    repeat (20) @(posedge ref_clk);
    rd_chk("cont_hold", CNT, 32'h0);
    fire(4'h2, 4'h0);
    repeat (20) @(posedge ref_clk);
    fire(4'h2, 4'h0);
    repeat (3) @(posedge ref_clk);
    rd_chk("cont_reload", CNT, 32'h2);
    $display("test offset done");
    final_report();
  end
endmodule
